/* File: include/edge_irq_gpio_pkg.sv */
`default_nettype none
package edge_irq_gpio_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_WIDE_EDGE_FLAGS = 8'h1F;
    localparam logic [7:0] IDX_NARROW_DATA = 8'h28;
    localparam logic [7:0] IDX_NARROW_PIN_INPUT = 8'h29;
    localparam logic [7:0] IDX_NARROW_DIRECTION = 8'h2A;
    localparam logic [7:0] IDX_NARROW_DRIVE = 8'h2B;
    localparam logic [7:0] IDX_NARROW_PULL_EN = 8'h2C;
    localparam logic [7:0] IDX_NARROW_POLARITY = 8'h2D;
    localparam logic [7:0] IDX_NARROW_IRQ_EN = 8'h2E;
    localparam logic [7:0] IDX_NARROW_EDGE_FLAGS = 8'h2F;
    localparam logic [7:0] IDX_WIDE_POLARITY = 8'h1D;
    localparam logic [7:0] IDX_WIDE_IRQ_EN = 8'h1E;
    localparam logic [7:0] IDX_WIDE_WIRED_OR = 8'h1A;
    // sticky event status (read clears) and its mask
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h3C;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h3D;
    localparam int ADDR_W = 8;
    // narrow port uses pins 7 and 6 only
    localparam logic [7:0] NARROW_PIN_MASK = 8'hC0;
    localparam logic [7:0] REG_RESET = 8'h00;
    // status bit positions
    localparam int ST_WIDE_EDGE = 0;
    localparam int ST_NARROW_EDGE = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // polarity encoding
    localparam logic POL_FALLING = 1'b0;
    localparam logic POL_RISING = 1'b1;
endpackage
`default_nettype wire

/* File: rtl/edge_irq_gpio_port.sv */
// Behaviour
// - each wide-port edge flag sets on the selected edge of its pin
// - edge flags readable anytime; write one clears, zero leaves unchanged
// - interrupt request raised when a set flag has its enable set
// - per-pin polarity bit chooses rising or falling active edge
// - data read returns output latch for output pins, pin level otherwise
// - pin input register always returns pin levels; writes ignored
// - direction bits for pins 7 and 6: zero input, one output
// - readback may lag direction changes by up to two bus cycles
// - reduced drive bit acts only on output pins: zero full, one third
// - pull enable active for inputs or wired-or outputs, not push-pull; narrow pins here are push-pull only, so pulls act on inputs only
// - falling polarity: falling edge sets flag, pull-up when enabled input
// - rising polarity: rising edge sets flag, pull-down when enabled input
// - narrow-port flags 7 and 6 set by active edge, write one clears
// - narrow-port pins 7 and 6 each have an interrupt enable bit
// - each wide-port pin has an interrupt enable bit
`timescale 1ns/1ps
`default_nettype none
module edge_irq_gpio_port
    import edge_irq_gpio_pkg::*;
#(
    parameter int WIDE_PINS = 8
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // wide port pins (input only here)
    input wire logic [WIDE_PINS-1:0] wide_pin_in,
    // narrow port pins, three-signal form
    input wire logic [7:0] narrow_pin_in,
    output logic [7:0] narrow_pin_out,
    output logic [7:0] narrow_pin_oe,
    // pad controls
    output logic [7:0] narrow_reduced_drive,
    output logic [7:0] narrow_pull_up_en,
    output logic [7:0] narrow_pull_down_en,
    output logic [WIDE_PINS-1:0] wide_pull_up_en,
    output logic [WIDE_PINS-1:0] wide_pull_down_en,
    // interrupts
    output logic wide_port_irq,
    output logic narrow_port_irq,
    output logic irq
);
    // pin synchronisers
    logic [WIDE_PINS-1:0] wide_meta_reg, wide_sync_reg, wide_prev_reg;
    logic [7:0] narrow_meta_reg, narrow_sync_reg, narrow_prev_reg;
    // software registers
    logic [7:0] narrow_port_data_reg;
    logic [7:0] narrow_port_direction_reg;
    logic [7:0] narrow_port_drive_strength_reg;
    logic [7:0] narrow_port_pull_enable_reg;
    logic [7:0] narrow_port_polarity_select_reg;
    logic [7:0] narrow_port_irq_enable_reg;
    logic [7:0] narrow_port_edge_flags_reg;
    logic [WIDE_PINS-1:0] wide_port_polarity_select_reg;
    logic [WIDE_PINS-1:0] wide_port_irq_enable_reg;
    logic [WIDE_PINS-1:0] wide_port_edge_flags_reg;
    logic [WIDE_PINS-1:0] wide_pull_enable_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    // bus slave state
    logic [ADDR_W-1:0] aw_idx_reg, ar_idx_reg;
    logic aw_held_reg, w_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] bresp_reg, rresp_reg;

    // synchroniser first stage is read only by the second
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wide_meta_reg <= '0;
            wide_sync_reg <= '0;
            wide_prev_reg <= '0;
            narrow_meta_reg <= 8'h00;
            narrow_sync_reg <= 8'h00;
            narrow_prev_reg <= 8'h00;
        end
        else
        begin
            wide_meta_reg <= wide_pin_in;
            wide_sync_reg <= wide_meta_reg;
            wide_prev_reg <= wide_sync_reg;
            narrow_meta_reg <= narrow_pin_in;
            narrow_sync_reg <= narrow_meta_reg;
            narrow_prev_reg <= narrow_sync_reg;
        end
    end

    // active-edge detection; polarity zero picks falling, one rising
    wire [WIDE_PINS-1:0] wide_rise = wide_sync_reg & ~wide_prev_reg;
    wire [WIDE_PINS-1:0] wide_fall = ~wide_sync_reg & wide_prev_reg;
    wire [WIDE_PINS-1:0] wide_edge = (wide_port_polarity_select_reg & wide_rise)
        | (~wide_port_polarity_select_reg & wide_fall);
    wire [7:0] narrow_rise = narrow_sync_reg & ~narrow_prev_reg;
    wire [7:0] narrow_fall = ~narrow_sync_reg & narrow_prev_reg;
    wire [7:0] narrow_edge = ((narrow_port_polarity_select_reg & narrow_rise)
        | (~narrow_port_polarity_select_reg & narrow_fall)) & NARROW_PIN_MASK;

    // bus write decode; address and data may arrive in either order
    wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_ok = do_write && wstrb_reg[0];
    wire [7:0] wbyte = wdata_reg[7:0];
    wire wr_wide_flags = wr_ok && (aw_idx_reg == IDX_WIDE_EDGE_FLAGS);
    wire wr_wide_pol = wr_ok && (aw_idx_reg == IDX_WIDE_POLARITY);
    wire wr_wide_ien = wr_ok && (aw_idx_reg == IDX_WIDE_IRQ_EN);
    wire wr_wide_pull = wr_ok && (aw_idx_reg == IDX_WIDE_WIRED_OR);
    wire wr_data = wr_ok && (aw_idx_reg == IDX_NARROW_DATA);
    wire wr_dir = wr_ok && (aw_idx_reg == IDX_NARROW_DIRECTION);
    wire wr_drv = wr_ok && (aw_idx_reg == IDX_NARROW_DRIVE);
    wire wr_pull = wr_ok && (aw_idx_reg == IDX_NARROW_PULL_EN);
    wire wr_pol = wr_ok && (aw_idx_reg == IDX_NARROW_POLARITY);
    wire wr_ien = wr_ok && (aw_idx_reg == IDX_NARROW_IRQ_EN);
    wire wr_nflags = wr_ok && (aw_idx_reg == IDX_NARROW_EDGE_FLAGS);
    wire wr_mask = wr_ok && (aw_idx_reg == IDX_IRQ_MASK);
    wire wr_known = (aw_idx_reg == IDX_WIDE_EDGE_FLAGS) || (aw_idx_reg == IDX_WIDE_POLARITY)
        || (aw_idx_reg == IDX_WIDE_IRQ_EN) || (aw_idx_reg == IDX_WIDE_WIRED_OR)
        || ((aw_idx_reg >= IDX_NARROW_DATA) && (aw_idx_reg <= IDX_NARROW_EDGE_FLAGS))
        || (aw_idx_reg == IDX_IRQ_STATUS) || (aw_idx_reg == IDX_IRQ_MASK);

    // write-one-to-clear, but a same-cycle edge wins over the clear
    wire [WIDE_PINS-1:0] wide_clr = wr_wide_flags ? wbyte[WIDE_PINS-1:0] : '0;
    wire [7:0] narrow_clr = wr_nflags ? wbyte : 8'h00;
    wire [WIDE_PINS-1:0] wide_flags_next = (wide_port_edge_flags_reg & ~wide_clr) | wide_edge;
    wire [7:0] narrow_flags_next = (narrow_port_edge_flags_reg & ~narrow_clr) | narrow_edge;

    // per-port requests, masked per pin
    assign wide_port_irq = |(wide_port_edge_flags_reg & wide_port_irq_enable_reg);
    assign narrow_port_irq = |(narrow_port_edge_flags_reg & narrow_port_irq_enable_reg);

    // sticky status events: rising of each port request
    logic wide_irq_prev_reg, narrow_irq_prev_reg;
    wire [1:0] irq_event = {narrow_port_irq & ~narrow_irq_prev_reg,
        wide_port_irq & ~wide_irq_prev_reg};
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [ADDR_W-1:0] ar_idx_now = s_axi_araddr[ADDR_W+1:2];
    wire rd_status = rd_take && (ar_idx_now == IDX_IRQ_STATUS);
    wire [1:0] irq_status_next = (rd_status ? 2'h0 : irq_status_reg) | irq_event;
    assign irq = |(irq_status_reg & irq_mask_reg);

    // configuration registers, cleared at reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            narrow_port_data_reg <= REG_RESET;
            narrow_port_direction_reg <= REG_RESET;
            narrow_port_drive_strength_reg <= REG_RESET;
            narrow_port_pull_enable_reg <= REG_RESET;
            narrow_port_polarity_select_reg <= REG_RESET;
            narrow_port_irq_enable_reg <= REG_RESET;
            narrow_port_edge_flags_reg <= REG_RESET;
            wide_port_polarity_select_reg <= '0;
            wide_port_irq_enable_reg <= '0;
            wide_port_edge_flags_reg <= '0;
            wide_pull_enable_reg <= '0;
            irq_status_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            wide_irq_prev_reg <= 1'b0;
            narrow_irq_prev_reg <= 1'b0;
        end
        else
        begin
            if (wr_data) narrow_port_data_reg <= wbyte & NARROW_PIN_MASK;
            if (wr_dir) narrow_port_direction_reg <= wbyte & NARROW_PIN_MASK;
            if (wr_drv) narrow_port_drive_strength_reg <= wbyte & NARROW_PIN_MASK;
            if (wr_pull) narrow_port_pull_enable_reg <= wbyte & NARROW_PIN_MASK;
            if (wr_pol) narrow_port_polarity_select_reg <= wbyte & NARROW_PIN_MASK;
            if (wr_ien) narrow_port_irq_enable_reg <= wbyte & NARROW_PIN_MASK;
            if (wr_wide_pol) wide_port_polarity_select_reg <= wbyte[WIDE_PINS-1:0];
            if (wr_wide_ien) wide_port_irq_enable_reg <= wbyte[WIDE_PINS-1:0];
            if (wr_wide_pull) wide_pull_enable_reg <= wbyte[WIDE_PINS-1:0];
            if (wr_mask) irq_mask_reg <= wbyte[1:0];
            narrow_port_edge_flags_reg <= narrow_flags_next;
            wide_port_edge_flags_reg <= wide_flags_next;
            irq_status_reg <= irq_status_next;
            wide_irq_prev_reg <= wide_port_irq;
            narrow_irq_prev_reg <= narrow_port_irq;
        end
    end

    // pad drive: narrow pins are push-pull, so pulls act only as inputs
    assign narrow_pin_out = narrow_port_data_reg;
    assign narrow_pin_oe = narrow_port_direction_reg;
    assign narrow_reduced_drive = narrow_port_drive_strength_reg & narrow_port_direction_reg;
    wire [7:0] narrow_pull_act = narrow_port_pull_enable_reg & ~narrow_port_direction_reg;
    assign narrow_pull_up_en = narrow_pull_act & ~narrow_port_polarity_select_reg;
    assign narrow_pull_down_en = narrow_pull_act & narrow_port_polarity_select_reg;
    // wide port pins are inputs here, so pulls always apply when enabled
    assign wide_pull_up_en = wide_pull_enable_reg & ~wide_port_polarity_select_reg;
    assign wide_pull_down_en = wide_pull_enable_reg & wide_port_polarity_select_reg;

    // read mux; synchronised pin level lags a direction change by two cycles
    wire [7:0] data_view = (narrow_port_direction_reg & narrow_port_data_reg)
        | (~narrow_port_direction_reg & narrow_sync_reg & NARROW_PIN_MASK);
    logic [7:0] rd_byte;
    logic rd_known;
    always_comb
    begin
        rd_byte = 8'h00;
        rd_known = 1'b1;
        unique case (ar_idx_now)
            IDX_WIDE_EDGE_FLAGS: rd_byte = 8'(wide_port_edge_flags_reg);
            IDX_WIDE_POLARITY: rd_byte = 8'(wide_port_polarity_select_reg);
            IDX_WIDE_IRQ_EN: rd_byte = 8'(wide_port_irq_enable_reg);
            IDX_WIDE_WIRED_OR: rd_byte = 8'(wide_pull_enable_reg);
            IDX_NARROW_DATA: rd_byte = data_view;
            IDX_NARROW_PIN_INPUT: rd_byte = narrow_sync_reg & NARROW_PIN_MASK;
            IDX_NARROW_DIRECTION: rd_byte = narrow_port_direction_reg;
            IDX_NARROW_DRIVE: rd_byte = narrow_port_drive_strength_reg;
            IDX_NARROW_PULL_EN: rd_byte = narrow_port_pull_enable_reg;
            IDX_NARROW_POLARITY: rd_byte = narrow_port_polarity_select_reg;
            IDX_NARROW_IRQ_EN: rd_byte = narrow_port_irq_enable_reg;
            IDX_NARROW_EDGE_FLAGS: rd_byte = narrow_port_edge_flags_reg;
            IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status_reg};
            IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
            default: rd_known = 1'b0;
        endcase
    end

    // axi handshakes: one write and one read outstanding at a time
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // write channel: pin-input writes are accepted but change nothing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_idx_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_idx_reg <= s_axi_awaddr[ADDR_W+1:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    // read channel: data registered at address acceptance
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h000000, rd_byte};
            rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_reg <= 1'b0;
    end
endmodule // edge_irq_gpio_port
`default_nettype wire

/* File: verif/edge_irq_gpio_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_irq_gpio_port_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pad controls and interrupt
    input wire logic [7:0] narrow_pin_oe,
    input wire logic [7:0] narrow_reduced_drive,
    input wire logic [7:0] narrow_pull_up_en,
    input wire logic [7:0] narrow_pull_down_en,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // address and data of one write taken at one edge
    sequence seq_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence seq_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // both held at the next edge, answer registered one edge later
    chk_write_answer: assert property (seq_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    chk_read_answer: assert property (seq_rd_taken |=> s_axi_rvalid)
        else $error("read answer missing");
    chk_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_drive_gated: assert property ((narrow_reduced_drive & ~narrow_pin_oe) == 8'h00)
        else $error("reduced drive on input pin");
    chk_pull_gated: assert property (
        ((narrow_pull_up_en | narrow_pull_down_en) & narrow_pin_oe) == 8'h00)
        else $error("pull on driven pin");
    chk_pull_exclusive: assert property ((narrow_pull_up_en & narrow_pull_down_en) == 8'h00)
        else $error("pull up and down together");
    chk_narrow_bits: assert property ((narrow_pin_oe & 8'h3F) == 8'h00)
        else $error("direction on absent pin");
    // first edge after release must see cleared state
    chk_reset_clear: assert property ($rose(aresetn) |-> narrow_pin_oe == 8'h00
        && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("state not cleared by reset");
endmodule // edge_irq_gpio_port_chk
bind edge_irq_gpio_port edge_irq_gpio_port_chk edge_irq_gpio_port_chk_inst (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .narrow_pin_oe, .narrow_reduced_drive,
    .narrow_pull_up_en, .narrow_pull_down_en, .irq
);
`default_nettype wire

/* File: verif/pin_level_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_level_model (
    // clock
    input wire logic aclk,
    // outside world
    input wire logic [7:0] ext_level,
    input wire logic [7:0] ext_drive_en,
    // pad state from the port
    input wire logic [7:0] narrow_pin_out,
    input wire logic [7:0] narrow_pin_oe,
    input wire logic [7:0] narrow_pull_up_en,
    input wire logic [7:0] narrow_pull_down_en,
    // resolved pin levels
    output logic [7:0] narrow_pin_in
);
    logic [7:0] last_reg;
    // a floating pin wanders, so never show a stale level
    always_ff @(posedge aclk)
        last_reg <= narrow_pin_in;
    // port drive wins, then outside drive, then pulls
    assign narrow_pin_in = (narrow_pin_oe & narrow_pin_out)
        | (~narrow_pin_oe & ext_drive_en & ext_level)
        | (~narrow_pin_oe & ~ext_drive_en & (narrow_pull_up_en
        | (~narrow_pull_down_en & ~last_reg)));
endmodule // pin_level_model
`default_nettype wire

/* File: verif/edge_irq_gpio_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_irq_gpio_port_tb;
    import edge_irq_gpio_pkg::*;
    // design ports and bench state
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] wide_pin_in, narrow_pin_in, narrow_pin_out, narrow_pin_oe, narrow_reduced_drive;
    logic [7:0] narrow_pull_up_en, narrow_pull_down_en, wide_pull_up_en, wide_pull_down_en;
    logic wide_port_irq, narrow_port_irq, irq;
    logic [7:0] ext_level, ext_drive_en, p, en, m, d, dr, lv;
    logic [7:0] cfg [0:7];
    logic [7:0] rst_idx [0:13] = '{IDX_NARROW_DATA, IDX_NARROW_PIN_INPUT, IDX_NARROW_DIRECTION,
        IDX_NARROW_DRIVE, IDX_NARROW_PULL_EN, IDX_NARROW_POLARITY, IDX_NARROW_IRQ_EN,
        IDX_NARROW_EDGE_FLAGS, IDX_WIDE_POLARITY, IDX_WIDE_IRQ_EN, IDX_WIDE_EDGE_FLAGS,
        IDX_WIDE_WIRED_OR, IDX_IRQ_STATUS, IDX_IRQ_MASK};
    logic [7:0] rw_idx [0:7] = '{IDX_NARROW_DIRECTION, IDX_NARROW_DRIVE, IDX_NARROW_PULL_EN,
        IDX_NARROW_POLARITY, IDX_NARROW_IRQ_EN, IDX_WIDE_POLARITY, IDX_WIDE_IRQ_EN,
        IDX_WIDE_WIRED_OR};
    integer seed = 32'h9D2D;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    edge_irq_gpio_port #(.WIDE_PINS(8)) edge_irq_gpio_port_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .wide_pin_in, .narrow_pin_in, .narrow_pin_out,
        .narrow_pin_oe, .narrow_reduced_drive, .narrow_pull_up_en, .narrow_pull_down_en,
        .wide_pull_up_en, .wide_pull_down_en, .wide_port_irq, .narrow_port_irq, .irq);
    pin_level_model pin_level_model_inst (.aclk, .ext_level, .ext_drive_en, .narrow_pin_out,
        .narrow_pin_oe, .narrow_pull_up_en, .narrow_pull_down_en, .narrow_pin_in);

    // readback of the narrow port: latch where driven, pin level elsewhere
    function automatic logic [7:0] pin_exp(input logic [7:0] dv, ds, lvl);
        return ((dv & ds) | (lvl & ~ds)) & NARROW_PIN_MASK;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one bus transfer; ready is held back a random few cycles to stall answers
    task automatic xfer(input logic wr, input logic [7:0] idx, val);
        logic a, b;
        int n, st;
        n = 0;
        st = $random(seed) & 3;
        @(posedge aclk);
        s_axi_awaddr <= {22'h0, idx, 2'b00};
        s_axi_araddr <= {22'h0, idx, 2'b00};
        s_axi_wdata <= {24'h0, val};
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        do
        begin
            @(negedge aclk);
            a = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
            a = a | (s_axi_arvalid & s_axi_arready);
            b = wr ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
            resp = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge aclk);
            n++;
            if (a)
            begin
                s_axi_awvalid <= 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            s_axi_bready <= wr && n > st && !b;
            s_axi_rready <= !wr && n > st && !b;
        end while (!b);
    endtask

    // clock
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // hang guard
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    // main sequence
    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        wide_pin_in = 8'h00;
        ext_level = 8'h00;
        ext_drive_en = 8'hFF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rst_idx[i])
        begin
            xfer(1'b0, rst_idx[i], 8'h00);
            check("reset value", rd, 32'h0);
        end
        xfer(1'b0, 8'h00, 8'h00);
        check("unmapped resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        foreach (rw_idx[i])
        begin
            cfg[i] = 8'($random(seed));
            xfer(1'b1, rw_idx[i], cfg[i]);
            xfer(1'b0, rw_idx[i], 8'h00);
            check("reg rw", rd, {24'h0, cfg[i] & (rw_idx[i][7:4] == 4'h2 ? 8'hC0 : 8'hFF)});
        end
        @(negedge aclk);
        check("drive", narrow_reduced_drive, cfg[1] & cfg[0] & 8'hC0);
        check("pull up", narrow_pull_up_en, cfg[2] & ~cfg[0] & ~cfg[3] & 8'hC0);
        check("pull down", narrow_pull_down_en, cfg[2] & ~cfg[0] & cfg[3] & 8'hC0);
        check("wide pull down", wide_pull_down_en, cfg[7] & cfg[5]);
        check("wide pull up", wide_pull_up_en, cfg[7] & ~cfg[5]);
        for (int k = 0; k < 4; k++)
        begin
            d = 8'($random(seed));
            dr = 8'($random(seed));
            lv = 8'($random(seed));
            xfer(1'b1, IDX_NARROW_DATA, d);
            xfer(1'b1, IDX_NARROW_DIRECTION, dr);
            ext_level <= lv;
            repeat (4) @(posedge aclk);
            xfer(1'b0, IDX_NARROW_DATA, 8'h00);
            check("data read", rd, {24'h0, pin_exp(d, dr, lv)});
            check("pin out", narrow_pin_out, d & NARROW_PIN_MASK);
            xfer(1'b1, IDX_NARROW_PIN_INPUT, ~lv);
            xfer(1'b0, IDX_NARROW_PIN_INPUT, 8'h00);
            check("pin input", rd, {24'h0, pin_exp(d, dr, lv)});
        end
        // floating inputs: pin 7 pulled down, pin 6 pulled up
        xfer(1'b1, IDX_NARROW_DIRECTION, 8'h00);
        xfer(1'b1, IDX_NARROW_PULL_EN, 8'hC0);
        xfer(1'b1, IDX_NARROW_POLARITY, 8'h80);
        ext_drive_en <= 8'h3F;
        repeat (4) @(posedge aclk);
        xfer(1'b0, IDX_NARROW_PIN_INPUT, 8'h00);
        check("pulled pins", rd, 32'h40);
        ext_drive_en <= 8'hFF;
        for (int k = 0; k < 3; k++)
        begin
            p = k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($random(seed));
            en = 8'($random(seed));
            m = 8'($random(seed));
            xfer(1'b1, IDX_WIDE_POLARITY, p);
            xfer(1'b1, IDX_WIDE_IRQ_EN, en);
            wide_pin_in <= ~p;
            repeat (6) @(posedge aclk);
            xfer(1'b1, IDX_WIDE_EDGE_FLAGS, 8'hFF);
            xfer(1'b0, IDX_WIDE_EDGE_FLAGS, 8'h00);
            check("flags cleared", rd, 32'h0);
            wide_pin_in <= p;
            repeat (6) @(posedge aclk);
            @(negedge aclk);
            check("wide irq", {31'h0, wide_port_irq}, {31'h0, |en});
            xfer(1'b0, IDX_WIDE_EDGE_FLAGS, 8'h00);
            check("wide flags", rd, 32'hFF);
            xfer(1'b1, IDX_WIDE_EDGE_FLAGS, m);
            @(negedge aclk);
            check("wide irq mask", {31'h0, wide_port_irq}, {31'h0, |(~m & en)});
            wide_pin_in <= ~p;
            repeat (6) @(posedge aclk);
            xfer(1'b0, IDX_WIDE_EDGE_FLAGS, 8'h00);
            check("inactive edge", rd, {24'h0, ~m});
        end
        xfer(1'b1, IDX_NARROW_POLARITY, 8'hC0);
        xfer(1'b1, IDX_NARROW_IRQ_EN, 8'h40);
        xfer(1'b1, IDX_IRQ_MASK, 8'h03);
        ext_level <= 8'h00;
        repeat (6) @(posedge aclk);
        xfer(1'b1, IDX_NARROW_EDGE_FLAGS, 8'hFF);
        xfer(1'b0, IDX_IRQ_STATUS, 8'h00);
        ext_level <= 8'hC0;
        repeat (6) @(posedge aclk);
        xfer(1'b0, IDX_NARROW_EDGE_FLAGS, 8'h00);
        check("narrow flags", rd, 32'hC0);
        xfer(1'b0, IDX_IRQ_STATUS, 8'h00);
        check("status", rd, 32'h2);
        xfer(1'b1, IDX_NARROW_EDGE_FLAGS, 8'h40);
        @(negedge aclk);
        check("narrow irq", {30'h0, narrow_port_irq, irq}, 32'h0);
        xfer(1'b1, IDX_IRQ_MASK, 8'h00);
        xfer(1'b1, IDX_NARROW_IRQ_EN, 8'hC0);
        @(negedge aclk);
        check("masked irq", {30'h0, narrow_port_irq, irq}, 32'h2);
        xfer(1'b1, IDX_IRQ_MASK, 8'h02);
        @(negedge aclk);
        check("unmasked irq", {31'h0, irq}, 32'h1);
        xfer(1'b0, IDX_IRQ_STATUS, 8'h00);
        @(negedge aclk);
        check("status read clears", {31'h0, irq}, 32'h0);
        final_report();
    end
endmodule // edge_irq_gpio_port_tb
`default_nettype wire
